/* File: rtl/prpdl_pkg.sv */
// Package for the dual-LAN redundancy entity: constants and carrier types.
// Assumes a single clock domain and byte-wide frame streams.
package prpdl_pkg;
  localparam int PRPDL_CNT_W = 32;
  localparam logic [31:0] PRPDL_CNT_RST = 32'h0000_0000;
  localparam logic [15:0] PRPDL_VLAN_RST = 16'h0000;
  localparam logic [15:0] PRPDL_SEQ_RST = 16'h0000;
  localparam logic [3:0] PRPDL_LAN_A_ID = 4'hA;
  localparam logic [3:0] PRPDL_LAN_B_ID = 4'hB;
  localparam int PRPDL_WIN_DEPTH = 16;

  // Byte stream beat.
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
  } prpdl_beat_t;

  // Trailer fields delivered by a receive port's parser at frame end.
  typedef struct packed {
    logic        done;     // one-cycle pulse at frame end
    logic        good;     // frame CRC/length ok
    logic        has_rct;  // redundancy trailer present and parsed
    logic [15:0] seq;
    logic [3:0]  lan_id;
  } prpdl_rx_info_t;

  // Per-LAN statistics.
  typedef struct packed {
    logic [31:0] valid_frames;
    logic [31:0] dup_frames;
    logic [31:0] wrong_lan;
    logic [31:0] out_seq;
    logic [31:0] out_seq_low;
  } prpdl_stats_t;

  typedef enum logic [1:0] {
    PRPDL_TX_IDLE,
    PRPDL_TX_BODY,
    PRPDL_TX_SEQ_HI,
    PRPDL_TX_SEQ_LO
  } prpdl_tx_state_t;
endpackage

/* File: rtl/prpdl_core.sv */
// Dual-LAN parallel redundancy entity: duplicate transmit, duplicate discard, statistics.
// Assumes the port parsers supply per-frame trailer info on mclk and the MAC accepts bytes.
`timescale 1ns/10ps
module prpdl_core #(
  parameter int WIN_DEPTH = prpdl_pkg::PRPDL_WIN_DEPTH // duplicate window depth
) (
  input wire logic mclk, // system clock, 125 MHz
  input wire logic reset_n, // asynchronous reset, active low
  input wire logic redundancy_en, // feature enable, sampled on mclk
  input wire logic vlan_en, // tag supervision frames
  input wire logic [15:0] vlan_id, // VLAN identifier for supervision frames
  input wire prpdl_pkg::prpdl_beat_t mac_tx, // outgoing stream from the MAC
  input wire logic mac_tx_super, // current frame is a supervision frame
  output logic mac_tx_ready, // MAC may advance a byte
  output prpdl_pkg::prpdl_beat_t first_network_port_tx, // LAN A transmit stream
  output prpdl_pkg::prpdl_beat_t second_network_port_tx, // LAN B transmit stream
  output logic [3:0] tx_lan_id_a, // LAN id appended on LAN A
  output logic [3:0] tx_lan_id_b, // LAN id appended on LAN B
  output logic tx_vlan_insert, // VLAN tag requested for current frame
  output logic [15:0] tx_vlan_tag, // VLAN id for the tag
  input wire prpdl_pkg::prpdl_rx_info_t first_network_port_rx, // LAN A frame info
  input wire prpdl_pkg::prpdl_rx_info_t second_network_port_rx, // LAN B frame info
  output logic accept_a, // pulse: LAN A frame passed to MAC
  output logic accept_b, // pulse: LAN B frame passed to MAC
  output logic drop_a, // pulse: LAN A frame discarded
  output logic drop_b, // pulse: LAN B frame discarded
  output prpdl_pkg::prpdl_stats_t stats_a, // LAN A statistics
  output prpdl_pkg::prpdl_stats_t stats_b, // LAN B statistics
  output logic [31:0] missing_frames // forward sequence jumps seen, one count per jump whatever its size
);
  import prpdl_pkg::*;

  // ==========================================================================
  // Configuration capture
  // ==========================================================================
  logic red_on;
  prpdl_tx_state_t tx_state;
  logic in_frame;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      red_on <= 1'b0;
    end else if ((tx_state == PRPDL_TX_IDLE && !mac_tx.valid) ||
                 (in_frame && mac_tx.last)) begin
      // Change only between frames so a frame is never half duplicated; a gap in
      // valid inside a frame body is not a frame boundary.
      red_on <= redundancy_en;
    end
  end

  // ==========================================================================
  // Transmit: one stream feeds both ports, trailer carries shared sequence
  // ==========================================================================
  logic [15:0] tx_seq;
  // Ready drops for the two trailer cycles; the MAC must hold its pending byte meanwhile.
  assign mac_tx_ready = (tx_state == PRPDL_TX_IDLE) || (tx_state == PRPDL_TX_BODY);
  assign in_frame = mac_tx.valid && mac_tx_ready;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tx_state <= PRPDL_TX_IDLE;
    end else begin
      case (tx_state)
        PRPDL_TX_IDLE: begin
          if (in_frame && mac_tx.last && red_on) begin
            tx_state <= PRPDL_TX_SEQ_HI;
          end else if (in_frame && !mac_tx.last) begin
            tx_state <= PRPDL_TX_BODY;
          end
        end
        PRPDL_TX_BODY: begin
          if (in_frame && mac_tx.last) begin
            tx_state <= red_on ? PRPDL_TX_SEQ_HI : PRPDL_TX_IDLE;
          end
        end
        PRPDL_TX_SEQ_HI: tx_state <= PRPDL_TX_SEQ_LO;
        PRPDL_TX_SEQ_LO: tx_state <= PRPDL_TX_IDLE;
        default: tx_state <= PRPDL_TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tx_seq <= PRPDL_SEQ_RST;
    end else if (tx_state == PRPDL_TX_SEQ_LO) begin
      tx_seq <= tx_seq + 16'h0001;
    end
  end

  // Both ports get byte-identical copies; the sequence is appended after the body.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      first_network_port_tx <= '0;
      second_network_port_tx <= '0;
    end else begin
      case (tx_state)
        PRPDL_TX_SEQ_HI: begin
          first_network_port_tx <= '{valid: 1'b1, data: tx_seq[15:8], last: 1'b0};
          second_network_port_tx <= '{valid: 1'b1, data: tx_seq[15:8], last: 1'b0};
        end
        PRPDL_TX_SEQ_LO: begin
          first_network_port_tx <= '{valid: 1'b1, data: tx_seq[7:0], last: 1'b1};
          second_network_port_tx <= '{valid: 1'b1, data: tx_seq[7:0], last: 1'b1};
        end
        default: begin
          first_network_port_tx <= '{valid: in_frame, data: mac_tx.data,
                                     last: mac_tx.last && !red_on};
          // Without redundancy LAN B stays silent; the single MAC uses LAN A only.
          second_network_port_tx <= '{valid: in_frame && red_on, data: mac_tx.data,
                                      last: 1'b0};
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tx_lan_id_a <= PRPDL_LAN_A_ID;
      tx_lan_id_b <= PRPDL_LAN_B_ID;
      tx_vlan_insert <= 1'b0;
      tx_vlan_tag <= PRPDL_VLAN_RST;
    end else begin
      tx_lan_id_a <= PRPDL_LAN_A_ID;
      tx_lan_id_b <= PRPDL_LAN_B_ID;
      tx_vlan_insert <= vlan_en && mac_tx_super && mac_tx.valid;
      tx_vlan_tag <= vlan_en ? vlan_id : PRPDL_VLAN_RST;
    end
  end

  // ==========================================================================
  // Receive: duplicate discard over a window of recent sequence numbers
  // ==========================================================================
  logic [15:0] win [WIN_DEPTH];
  logic [WIN_DEPTH-1:0] win_vld;
  logic [15:0] exp_seq;
  logic seq_known;
  logic ok_a, ok_b, hit_a, hit_b, take_a, take_b, pass_b_dup;
  logic [WIN_DEPTH-1:0] m_a, m_b;
  logic [15:0] ofs_a, ofs_b;

  assign ok_a = first_network_port_rx.done && first_network_port_rx.good &&
                first_network_port_rx.has_rct && red_on;
  assign ok_b = second_network_port_rx.done && second_network_port_rx.good &&
                second_network_port_rx.has_rct && red_on;

  genvar gi;
  generate
    for (gi = 0; gi < WIN_DEPTH; gi++) begin : g_win
      assign m_a[gi] = win_vld[gi] && (win[gi] == first_network_port_rx.seq);
      assign m_b[gi] = win_vld[gi] && (win[gi] == second_network_port_rx.seq);
    end
  endgenerate

  // A sequence older than the window is taken as new, so a window shallower than
  // the worst skew between the LANs lets late duplicates through.
  assign hit_a = |m_a;
  // Same-cycle copies: LAN A wins, LAN B's copy is then the duplicate.
  assign pass_b_dup = ok_a && (first_network_port_rx.seq == second_network_port_rx.seq);
  assign hit_b = (|m_b) || pass_b_dup;
  assign take_a = ok_a && !hit_a;
  assign take_b = ok_b && !hit_b;
  assign ofs_a = first_network_port_rx.seq - exp_seq;
  assign ofs_b = second_network_port_rx.seq - exp_seq;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      win_vld <= '0;
      for (int i = 0; i < WIN_DEPTH; i++) begin
        win[i] <= PRPDL_SEQ_RST;
      end
    end else if (take_a && take_b) begin
      // Both accept in one cycle: B lands one slot deep, A in slot 0.
      for (int i = WIN_DEPTH - 1; i > 1; i--) begin
        win[i] <= win[i-2];
        win_vld[i] <= win_vld[i-2];
      end
      win[1] <= second_network_port_rx.seq;
      win_vld[1] <= 1'b1;
      win[0] <= first_network_port_rx.seq;
      win_vld[0] <= 1'b1;
    end else if (take_a || take_b) begin
      for (int i = WIN_DEPTH - 1; i > 0; i--) begin
        win[i] <= win[i-1];
        win_vld[i] <= win_vld[i-1];
      end
      win[0] <= take_a ? first_network_port_rx.seq : second_network_port_rx.seq;
      win_vld[0] <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      exp_seq <= PRPDL_SEQ_RST;
      seq_known <= 1'b0;
    end else if (take_a) begin
      exp_seq <= first_network_port_rx.seq + 16'h0001;
      seq_known <= 1'b1;
    end else if (take_b) begin
      exp_seq <= second_network_port_rx.seq + 16'h0001;
      seq_known <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      accept_a <= 1'b0;
      accept_b <= 1'b0;
      drop_a <= 1'b0;
      drop_b <= 1'b0;
    end else begin
      accept_a <= take_a;
      accept_b <= take_b;
      drop_a <= ok_a && hit_a;
      drop_b <= ok_b && hit_b;
    end
  end

  // ==========================================================================
  // Statistics: 32-bit wrapping counters, cleared by reset only
  // ==========================================================================
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stats_a <= '0;
    end else begin
      if (ok_a) stats_a.valid_frames <= stats_a.valid_frames + 32'h0000_0001;
      if (ok_a && hit_a) stats_a.dup_frames <= stats_a.dup_frames + 32'h0000_0001;
      if (ok_a && first_network_port_rx.lan_id != PRPDL_LAN_A_ID) begin
        stats_a.wrong_lan <= stats_a.wrong_lan + 32'h0000_0001;
      end
      if (take_a && seq_known && ofs_a != 16'h0000) begin
        stats_a.out_seq <= stats_a.out_seq + 32'h0000_0001;
      end
      if (take_a && seq_known && ofs_a[15]) begin
        stats_a.out_seq_low <= stats_a.out_seq_low + 32'h0000_0001;
      end
    end
  end

  // LAN B's sequence statistics are skipped when LAN A accepts in the same cycle,
  // because the expected value then follows A's frame, not B's.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stats_b <= '0;
    end else begin
      if (ok_b) stats_b.valid_frames <= stats_b.valid_frames + 32'h0000_0001;
      if (ok_b && hit_b) stats_b.dup_frames <= stats_b.dup_frames + 32'h0000_0001;
      if (ok_b && second_network_port_rx.lan_id != PRPDL_LAN_B_ID) begin
        stats_b.wrong_lan <= stats_b.wrong_lan + 32'h0000_0001;
      end
      if (take_b && !take_a && seq_known && ofs_b != 16'h0000) begin
        stats_b.out_seq <= stats_b.out_seq + 32'h0000_0001;
      end
      if (take_b && !take_a && seq_known && ofs_b[15]) begin
        stats_b.out_seq_low <= stats_b.out_seq_low + 32'h0000_0001;
      end
    end
  end

  // A forward jump past the expected value means both copies of a frame were lost.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      missing_frames <= PRPDL_CNT_RST;
    end else if (seq_known && ((take_a && ofs_a != 16'h0000 && !ofs_a[15]) ||
                               (!take_a && take_b && ofs_b != 16'h0000 && !ofs_b[15]))) begin
      missing_frames <= missing_frames + 32'h0000_0001;
    end
  end

endmodule // prpdl_core

/* File: test/prpdl_core_props.sv */
// Checker for the dual-LAN redundancy entity, watching top-level ports only.
// Assumes one clock domain and that redundancy_en changes only between frames.
`timescale 1ns/10ps
module prpdl_core_props
  import prpdl_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic reset_n, // reset
  input wire logic redundancy_en, // enable
  input wire logic vlan_en, // tag enable
  input wire logic [15:0] vlan_id, // tag value
  input wire prpdl_beat_t mac_tx, // MAC stream
  input wire logic mac_tx_super, // supervision
  input wire logic mac_tx_ready, // ready
  input wire prpdl_beat_t first_network_port_tx, // LAN A out
  input wire prpdl_beat_t second_network_port_tx, // LAN B out
  input wire logic tx_vlan_insert, // tag request
  input wire logic [15:0] tx_vlan_tag, // tag value out
  input wire prpdl_rx_info_t first_network_port_rx, // LAN A info
  input wire logic accept_a, // accept A
  input wire logic drop_a, // drop A
  input wire logic drop_b, // drop B
  input wire prpdl_stats_t stats_a, // LAN A stats
  input wire prpdl_stats_t stats_b // LAN B stats
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // Sequences
  sequence s_take;
    mac_tx.valid && mac_tx_ready;
  endsequence
  sequence s_rx_a;
    first_network_port_rx.done && first_network_port_rx.good &&
      first_network_port_rx.has_rct && redundancy_en;
  endsequence
  // ==========================================================
  // Properties
  property p_fwd;
    s_take |=> first_network_port_tx.valid && first_network_port_tx.data == $past(mac_tx.data);
  endproperty
  a_fwd: assert property (p_fwd) else $error("byte not forwarded");
  property p_copy;
    second_network_port_tx.valid |-> first_network_port_tx == second_network_port_tx;
  endproperty
  a_copy: assert property (p_copy) else $error("copies differ");
  property p_trail;
    $fell(mac_tx_ready) |=> !mac_tx_ready ##1 mac_tx_ready;
  endproperty
  a_trail: assert property (p_trail) else $error("trailer gap not two");
  property p_vins;
    tx_vlan_insert == $past(vlan_en && mac_tx_super && mac_tx.valid);
  endproperty
  a_vins: assert property (p_vins) else $error("tag request wrong");
  property p_vtag;
    tx_vlan_tag == ($past(vlan_en) ? $past(vlan_id) : 16'h0000);
  endproperty
  a_vtag: assert property (p_vtag) else $error("tag value wrong");
  property p_rx_ans;
    s_rx_a |=> accept_a ^ drop_a;
  endproperty
  a_rx_ans: assert property (p_rx_ans) else $error("no verdict");
  property p_vcnt;
    accept_a || drop_a |-> stats_a.valid_frames == $past(stats_a.valid_frames) + 32'h1;
  endproperty
  a_vcnt: assert property (p_vcnt) else $error("valid count");
  property p_dcnt;
    drop_b |-> stats_b.dup_frames == $past(stats_b.dup_frames) + 32'h1;
  endproperty
  a_dcnt: assert property (p_dcnt) else $error("dup count");
  property p_dhold;
    !drop_b |-> $stable(stats_b.dup_frames);
  endproperty
  a_dhold: assert property (p_dhold) else $error("dup count moved");
  property p_quiet;
    !$past(first_network_port_rx.done) |-> !accept_a && !drop_a;
  endproperty
  a_quiet: assert property (p_quiet) else $error("spurious verdict");
endmodule // prpdl_core_props
bind prpdl_core prpdl_core_props u_props (.mclk, .reset_n, .redundancy_en, .vlan_en,
  .vlan_id, .mac_tx, .mac_tx_super, .mac_tx_ready, .first_network_port_tx,
  .second_network_port_tx, .tx_vlan_insert, .tx_vlan_tag, .first_network_port_rx,
  .accept_a, .drop_a, .drop_b, .stats_a, .stats_b);

/* File: test/prpdl_lan_model.sv */
// Model of the two LANs: collects transmitted bytes and delivers frame trailers.
// Assumes callers enter deliver just after a rising edge of mclk.
`timescale 1ns/10ps
module prpdl_lan_model
  import prpdl_pkg::*;
(
  input wire logic mclk, // clock
  input wire prpdl_beat_t tx_a, // LAN A stream
  input wire prpdl_beat_t tx_b, // LAN B stream
  output prpdl_rx_info_t rx_a, // LAN A info
  output prpdl_rx_info_t rx_b // LAN B info
);
  logic [7:0] qa[$];
  logic [7:0] qb[$];
  initial begin
    rx_a = '0;
    rx_b = '0;
  end
  always @(posedge mclk) begin
    if (tx_a.valid) qa.push_back(tx_a.data);
    if (tx_b.valid) qb.push_back(tx_b.data);
  end
  task automatic deliver(input logic [1:0] on, input logic [15:0] seq,
                         input logic [3:0] ida, input logic [3:0] idb);
    rx_a = '{on[0], 1'b1, 1'b1, seq, ida};
    rx_b = '{on[1], 1'b1, 1'b1, seq, idb};
    @(posedge mclk);
    #1;
    // Stale fields are scrambled so nothing can lean on them after the pulse.
    rx_a = '{1'b0, 1'b0, 1'b0, ~seq, ~ida};
    rx_b = '{1'b0, 1'b0, 1'b0, ~seq, ~idb};
  endtask
endmodule // prpdl_lan_model

/* File: test/prpdl_core_test.sv */
// Self-checking bench for the dual-LAN redundancy entity.
// Assumes the LAN model file and the checker are compiled alongside.
`timescale 1ns/10ps
module prpdl_core_test;
  import prpdl_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic redundancy_en = 1'b0;
  logic vlan_en = 1'b0;
  logic [15:0] vlan_id = 16'h0000;
  prpdl_beat_t mac_tx = '0;
  logic mac_tx_super = 1'b0;
  logic mac_tx_ready, tx_vlan_insert, accept_a, accept_b, drop_a, drop_b;
  prpdl_beat_t tx_a, tx_b;
  logic [3:0] id_a, id_b;
  logic [15:0] tx_vlan_tag;
  prpdl_rx_info_t rx_a, rx_b;
  prpdl_stats_t stats_a, stats_b;
  logic [31:0] missing_frames;
  int failures = 0;
  int checks = 0;
  always #4 mclk = ~mclk;
  prpdl_core uut (.mclk, .reset_n, .redundancy_en, .vlan_en, .vlan_id, .mac_tx,
    .mac_tx_super, .mac_tx_ready, .first_network_port_tx(tx_a),
    .second_network_port_tx(tx_b), .tx_lan_id_a(id_a), .tx_lan_id_b(id_b),
    .tx_vlan_insert, .tx_vlan_tag, .first_network_port_rx(rx_a),
    .second_network_port_rx(rx_b), .accept_a, .accept_b, .drop_a, .drop_b,
    .stats_a, .stats_b, .missing_frames);
  prpdl_lan_model lan (.mclk, .tx_a, .tx_b, .rx_a, .rx_b);
  // ==========================================================
  // Tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task tx_frame(input logic [7:0] base, input int n, input logic sup);
    for (int i = 0; i < n; i++) begin
      mac_tx = '{1'b1, base + 8'(i), i == n - 1};
      mac_tx_super = sup;
      // Ready moves only on an edge, so its value here is what the next edge samples.
      while (!mac_tx_ready) begin
        @(posedge mclk);
        #1;
      end
      @(posedge mclk);
      #1;
    end
    mac_tx = '0;
    mac_tx_super = 1'b0;
  endtask
  task cmp_q(input logic [7:0] q[$], input logic [7:0] e[$]);
    check(q.size(), e.size());
    foreach (e[i]) check(q[i], e[i]);
  endtask
  // ==========================================================
  // Tests
  initial begin
    #100000;
    failures++;
    test_done;
  end
  initial begin
    repeat (20) @(posedge mclk);
    #1 reset_n = 1'b1;
    check(missing_frames, 32'h0);
    check(stats_b.dup_frames, 32'h0);
    tx_frame(8'h10, 2, 1'b0);
    redundancy_en = 1'b1;
    vlan_en = 1'b1;
    vlan_id = 16'hFFFF;
    repeat (2) @(posedge mclk);
    #1;
    tx_frame(8'h20, 2, 1'b1);
    @(posedge mclk);
    #1;
    tx_frame(8'h30, 1, 1'b0);
    repeat (4) @(posedge mclk);
    #1;
    cmp_q(lan.qa, '{8'h10, 8'h11, 8'h20, 8'h21, 8'h00, 8'h00, 8'h30, 8'h00, 8'h01});
    cmp_q(lan.qb, '{8'h20, 8'h21, 8'h00, 8'h00, 8'h30, 8'h00, 8'h01});
    check(id_b, PRPDL_LAN_B_ID);
    check(id_a, PRPDL_LAN_A_ID);
    check(tx_vlan_tag, 32'h0000_FFFF);
    lan.deliver(2'b01, 16'h0005, PRPDL_LAN_A_ID, PRPDL_LAN_B_ID);
    check(accept_a, 1'b1);
    lan.deliver(2'b10, 16'h0005, PRPDL_LAN_A_ID, PRPDL_LAN_B_ID);
    check(drop_b, 1'b1);
    lan.deliver(2'b11, 16'h0006, PRPDL_LAN_A_ID, PRPDL_LAN_B_ID);
    check({accept_a, drop_b, accept_b}, 3'h6);
    check(stats_b.dup_frames, 32'h2);
    lan.deliver(2'b01, 16'h0007, PRPDL_LAN_B_ID, PRPDL_LAN_B_ID);
    check(stats_a.wrong_lan, 32'h1);
    lan.deliver(2'b01, 16'h000A, PRPDL_LAN_A_ID, PRPDL_LAN_B_ID);
    check(missing_frames, 32'h1);
    check(stats_a.out_seq, 32'h1);
    lan.deliver(2'b01, 16'h0002, PRPDL_LAN_A_ID, PRPDL_LAN_B_ID);
    check(stats_a.out_seq_low, 32'h1);
    check(stats_a.out_seq, 32'h2);
    check(stats_a.valid_frames, 32'h5);
    lan.deliver(2'b10, 16'h000C, PRPDL_LAN_A_ID, PRPDL_LAN_A_ID);
    check({accept_b, drop_b}, 2'h2);
    check(stats_b.wrong_lan, 32'h1);
    check(stats_b.out_seq, 32'h1);
    check(missing_frames, 32'h2);
    lan.deliver(2'b10, 16'h0001, PRPDL_LAN_A_ID, PRPDL_LAN_B_ID);
    check(stats_b.out_seq_low, 32'h1);
    check(stats_b.out_seq, 32'h2);
    check(stats_b.valid_frames, 32'h4);
    redundancy_en = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    lan.deliver(2'b01, 16'h000B, PRPDL_LAN_A_ID, PRPDL_LAN_B_ID);
    check(accept_a, 1'b0);
    check(stats_a.valid_frames, 32'h5);
    test_done;
  end
endmodule // prpdl_core_test
